//--- design/srpmc_pkg.sv
package srpmc_pkg;

   // Transaction framing
   localparam int ADDR_W         = 7;
   localparam int DATA_W         = 8;
   localparam int NUM_REGS       = 128;
   localparam logic [2:0] BIT_LAST = 3'h7;

   // Register offsets
   localparam logic [6:0] OPMODE_ADDR = 7'h07;
   localparam logic [6:0] OSCCTL_ADDR = 7'h62;

   // Mode-control field positions
   localparam int XTAL_BIT = 0;
   localparam int SYNTH_BIT = 1;
   localparam int RXREQ_BIT = 2;
   localparam int TXREQ_BIT = 3;
   localparam int TSENS_BIT = 4;
   localparam int LBAT_BIT = 5;
   localparam int WUT_BIT = 6;
   localparam int SWRST_BIT = 7;

   // Reset values
   localparam logic [7:0] OPMODE_RST = 8'h01;
   localparam logic [7:0] REG_RST    = 8'h00;

   // Clock rate and entry times
   localparam int CLK_MHZ        = 250;
   localparam int T_SHUT_US      = 16210;
   localparam int T_STBY_US      = 1210;
   localparam int T_READY_US     = 210;
   localparam int T_TUNE_US      = 200;
   // Entry times in system clock cycles, exact
   localparam int CYC_SHUT       = T_SHUT_US * CLK_MHZ;
   localparam int CYC_STBY       = T_STBY_US * CLK_MHZ;
   localparam int CYC_READY      = T_READY_US * CLK_MHZ;
   localparam int CYC_TUNE       = T_TUNE_US * CLK_MHZ;

   typedef enum logic [1:0] {SRPMC_SHUT, SRPMC_IDLE, SRPMC_TX, SRPMC_RX} srpmc_state_t;
   typedef enum logic [2:0] {
      SRPMC_STANDBY, SRPMC_SLEEP, SRPMC_SENSOR, SRPMC_READY, SRPMC_TUNE
   } srpmc_idle_t;

endpackage

//--- design/srpmc_mode_ctrl.sv
`timescale 1ns/1ps
module srpmc_mode_ctrl
   import srpmc_pkg::*;
#(
   parameter int unsigned SHUT_CYC  = CYC_SHUT,
   parameter int unsigned STBY_CYC  = CYC_STBY,
   parameter int unsigned READY_CYC = CYC_READY,
   parameter int unsigned TUNE_CYC  = CYC_TUNE
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         shutSync,
   input  wire logic         fromShut,
   input  wire logic [7:0]   modeReg,
   output srpmc_state_t      state,
   output srpmc_idle_t       idleMode,
   output logic              entryBusy
);

   logic [23:0] waitCnt;
   logic        txWant;
   logic        rxWant;
   logic        sensorOn;

   assign txWant   = modeReg[TXREQ_BIT];
   assign rxWant   = modeReg[RXREQ_BIT];
   assign sensorOn = modeReg[LBAT_BIT] | modeReg[TSENS_BIT];

   // Idle sub-mode decode, priority tune over ready over sensor over sleep
   always_comb begin
      if (modeReg[SYNTH_BIT]) begin
         idleMode = SRPMC_TUNE;
      end else if (modeReg[XTAL_BIT]) begin
         idleMode = SRPMC_READY;
      end else if (sensorOn) begin
         idleMode = SRPMC_SENSOR;
      end else if (modeReg[WUT_BIT]) begin
         idleMode = SRPMC_SLEEP;
      end else begin
         idleMode = SRPMC_STANDBY;
      end
   end

   // Top-level state sequencing with bounded entry delay
   always_ff @(posedge clk) begin
      if (rst) begin
         state     <= SRPMC_SHUT;
         waitCnt   <= 24'h000000;
         entryBusy <= 1'b0;
      end else if (shutSync) begin
         state     <= SRPMC_SHUT;
         waitCnt   <= 24'h000000;
         entryBusy <= 1'b0;
      end else if (entryBusy) begin
         if (waitCnt <= 24'h000001) begin
            entryBusy <= 1'b0;
         end
         waitCnt <= waitCnt - 24'h000001;
      end else begin
         case (state)
            SRPMC_SHUT: begin
               state <= SRPMC_IDLE;
            end
            SRPMC_IDLE: begin
               if (txWant || rxWant) begin
                  state     <= txWant ? SRPMC_TX : SRPMC_RX;
                  entryBusy <= 1'b1;
                  if (fromShut) begin
                     waitCnt <= SHUT_CYC[23:0];
                  end else if (idleMode == SRPMC_TUNE) begin
                     waitCnt <= TUNE_CYC[23:0];
                  end else if (idleMode == SRPMC_READY) begin
                     waitCnt <= READY_CYC[23:0];
                  end else begin
                     waitCnt <= STBY_CYC[23:0];
                  end
               end
            end
            SRPMC_TX: begin
               if (!txWant && rxWant) begin
                  state     <= SRPMC_RX;
                  entryBusy <= 1'b1;
                  waitCnt   <= TUNE_CYC[23:0];
               end else if (!txWant) begin
                  state <= SRPMC_IDLE;
               end
            end
            SRPMC_RX: begin
               if (!rxWant && txWant) begin
                  state     <= SRPMC_TX;
                  entryBusy <= 1'b1;
                  waitCnt   <= TUNE_CYC[23:0];
               end else if (!rxWant) begin
                  state <= SRPMC_IDLE;
               end
            end
            default: begin
               state <= SRPMC_SHUT;
            end
         endcase
      end
   end

   a_entry_bound: assert property (@(posedge clk) disable iff (rst || shutSync)
      $rose(entryBusy) |-> entryBusy [*8])
      else $error("entry wait ended early");
   a_shut_enter: assert property (@(posedge clk) disable iff (rst)
      shutSync |=> state == SRPMC_SHUT)
      else $error("shutdown not entered");

endmodule // srpmc_mode_ctrl

//--- design/srpmc_top.sv
`timescale 1ns/1ps
// Overview of operation
// [R1] Frames are 16 bits: direction flag, seven address bits, eight data bits.
// [R2] Flag one writes a register, flag zero reads it.
// [R3] Seven-bit address picks one of 128 byte registers.
// [R4] Address or data byte is captured every eight serial clocks.
// [R5] Host keeps the serial clock at or below 10 MHz; the test host runs it at 31.25 MHz.
// [R6] On reads the eight incoming data bits are ignored.
// [R7] Read data shifts out on eight following falling serial edges.
// [R8] Output holds the last read bit while select stays low.
// [R9] Output released high through pull-up when select rises.
// [R10] Continued clocking under select increments address for each further byte.
// [R11] Controller has four states; idle has five sub-modes from mode register.
// [R12] Transmit or receive request from idle enters that state automatically.
// [R13] Entry times: 16.21 ms, 1.21 ms, 210 us, 200 us.
// [R14] Shutdown pin high forces shutdown; registers lost, serial port dead.
// [R15] Host holds shutdown pin low outside shutdown.
// [R16] Falling shutdown pin edge starts a power-on reset.
// [R17] After any reset or shutdown exit, ready sub-mode is default.
// [R18] Host reads interrupt status after power-on before low-power modes.
// [R19] Mode value zero selects standby; registers stay accessible.
// [R20] Wake-up timer bit, value 40h, selects sleep with timer running.
// [R21] Battery or temperature sensor bits select sensor mode, enabling them.
// [R22] Crystal bit selects ready mode, crystal kept running.
// [R23] Host writes 02h to oscillator control, clears bit 1 before leaving.
// [R24] Synthesizer bit selects tune; crystal forced on by hardware.
// [R25] Input sampled on rising edges, MSB first; frame starts on select fall.
module srpmc_top
   import srpmc_pkg::*;
#(
   parameter int unsigned SHUT_CYC  = CYC_SHUT,
   parameter int unsigned STBY_CYC  = CYC_STBY,
   parameter int unsigned READY_CYC = CYC_READY,
   parameter int unsigned TUNE_CYC  = CYC_TUNE
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         spiClk,
   input  wire logic         spiDin,
   input  wire logic         chip_select_n,
   input  wire logic         shutdown_pin,
   output logic              spiDout,
   output logic              spiDoutOe_n,
   output srpmc_state_t      radioState,
   output srpmc_idle_t       idleMode,
   output logic              entryBusy,
   output logic              xtalOn,
   output logic              synthOn,
   output logic              wakeTimerOn,
   output logic              lowBatOn,
   output logic              tempSensOn,
   output logic              porPulse
);

   // Synchroniser stages
   logic [1:0] sclkSync;
   logic [1:0] sdiSync;
   logic [1:0] csSync;
   logic [1:0] sdnSync;
   logic       sclkPrev;
   logic       csPrev;
   logic       sdnPrev;

   logic       sclkRise;
   logic       sclkFall;
   logic       csFall;
   logic       csHigh;
   logic       shutSync;
   logic       regClr;

   logic [7:0] regs [NUM_REGS];
   logic [7:0] shiftIn;
   logic [2:0] bitCnt;
   logic       inData;
   logic       isWrite;
   logic [6:0] addr;
   logic [7:0] shiftOut;
   logic       readActive;
   logic       fromShut;
   logic       soft_reset_cmd;
   logic [7:0] next_byte;

   // Two-stage synchronisers for all pin inputs
   always_ff @(posedge clk) begin
      if (rst) begin
         sclkSync <= 2'h0;
         sdiSync  <= 2'h0;
         csSync   <= 2'h3;
         sdnSync  <= 2'h3;
      end else begin
         sclkSync <= {sclkSync[0], spiClk};
         sdiSync  <= {sdiSync[0], spiDin};
         csSync   <= {csSync[0], chip_select_n};
         sdnSync  <= {sdnSync[0], shutdown_pin};
      end
   end

   // Edge history on synchronised levels
   always_ff @(posedge clk) begin
      if (rst) begin
         sclkPrev <= 1'b0;
         csPrev   <= 1'b1;
         sdnPrev  <= 1'b1;
      end else begin
         sclkPrev <= sclkSync[1];
         csPrev   <= csSync[1];
         sdnPrev  <= sdnSync[1];
      end
   end

   assign shutSync = sdnSync[1];
   assign csHigh   = csSync[1] | shutSync;                     // R14
   assign sclkRise = sclkSync[1] & ~sclkPrev & ~csHigh;        // R25
   assign sclkFall = ~sclkSync[1] & sclkPrev & ~csHigh;
   assign csFall   = ~csSync[1] & csPrev;                      // R25
   assign porPulse = sdnPrev & ~sdnSync[1];                    // R16
   assign regClr   = shutSync | porPulse | soft_reset_cmd;
   assign next_byte = {shiftIn[6:0], sdiSync[1]};              // R25

   // Serial frame receiver and byte framing
   always_ff @(posedge clk) begin
      if (rst || csHigh || csFall) begin
         bitCnt  <= 3'h0;
         shiftIn <= 8'h00;
         inData  <= 1'b0;
         isWrite <= 1'b0;
         addr    <= 7'h00;
      end else if (sclkRise) begin
         shiftIn <= next_byte;
         bitCnt  <= bitCnt + 3'h1;
         if (bitCnt == BIT_LAST) begin                         // R4
            if (!inData) begin
               isWrite <= next_byte[7];                        // R1 R2
               addr    <= next_byte[6:0];                      // R3
               inData  <= 1'b1;
            end else begin
               addr <= addr + 7'h01;                           // R10
            end
         end
      end
   end

   // Register array, cleared on shutdown and reset
   always_ff @(posedge clk) begin
      if (rst || regClr) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs[i] <= REG_RST;                                // R14
         end
         regs[OPMODE_ADDR] <= OPMODE_RST;                      // R17
      end else if (sclkRise && bitCnt == BIT_LAST && inData && isWrite) begin
         regs[addr] <= next_byte;                              // R2 R19
      end
   end

   // Soft reset request taken one cycle after a write sets it
   always_ff @(posedge clk) begin
      if (rst) begin
         soft_reset_cmd <= 1'b0;
      end else begin
         soft_reset_cmd <= regs[OPMODE_ADDR][SWRST_BIT] & ~soft_reset_cmd;
      end
   end

   // Read shifter; ignores incoming data bits during reads
   always_ff @(posedge clk) begin
      if (rst || csHigh || csFall) begin
         shiftOut   <= 8'hFF;
         readActive <= 1'b0;
      end else if (sclkRise && bitCnt == BIT_LAST && !(inData && isWrite)) begin
         if (!inData && !next_byte[7]) begin
            shiftOut   <= regs[next_byte[6:0]];                // R6 R7
            readActive <= 1'b1;
         end else if (inData && readActive) begin
            shiftOut <= regs[addr + 7'h01];                    // R10
         end
      end
   end

   // Output bit updated on falling serial edges, held afterwards
   always_ff @(posedge clk) begin
      if (rst || csHigh) begin
         spiDout     <= 1'b1;                                  // R9
         spiDoutOe_n <= 1'b1;
      end else if (sclkFall && readActive) begin
         spiDout     <= shiftOut[~bitCnt];                     // R7 R8
         spiDoutOe_n <= 1'b0;
      end
   end

   // Shutdown memory for the longest entry time
   always_ff @(posedge clk) begin
      if (rst || shutSync) begin
         fromShut <= 1'b1;
      end else if (radioState != SRPMC_SHUT && regs[OPMODE_ADDR] != OPMODE_RST) begin
         fromShut <= 1'b0;
      end
   end

   srpmc_mode_ctrl #(
      .SHUT_CYC  (SHUT_CYC),
      .STBY_CYC  (STBY_CYC),
      .READY_CYC (READY_CYC),
      .TUNE_CYC  (TUNE_CYC)
   ) u_mode (
      .clk       (clk),
      .rst       (rst),
      .shutSync  (shutSync),
      .fromShut  (fromShut),
      .modeReg   (regs[OPMODE_ADDR]),                          // R11 R12 R13
      .state     (radioState),
      .idleMode  (idleMode),
      .entryBusy (entryBusy)
   );

   // Block enables from the mode register, synthesizer also on in TX and RX, all off in shutdown
   always_comb begin
      xtalOn      = regs[OPMODE_ADDR][XTAL_BIT] | regs[OPMODE_ADDR][SYNTH_BIT]; // R22 R24
      synthOn     = regs[OPMODE_ADDR][SYNTH_BIT] | (radioState == SRPMC_TX)
                    | (radioState == SRPMC_RX);
      wakeTimerOn = regs[OPMODE_ADDR][WUT_BIT];                // R20
      lowBatOn    = regs[OPMODE_ADDR][LBAT_BIT];               // R21
      tempSensOn  = regs[OPMODE_ADDR][TSENS_BIT];              // R21
      if (radioState == SRPMC_SHUT) begin
         xtalOn      = 1'b0;
         synthOn     = 1'b0;
         wakeTimerOn = 1'b0;
         lowBatOn    = 1'b0;
         tempSensOn  = 1'b0;
      end
   end

   a_cs_pullup: assert property (@(posedge clk) disable iff (rst)
      csHigh |=> spiDout && spiDoutOe_n) // R9
      else $error("output not released");
   a_dout_hold: assert property (@(posedge clk) disable iff (rst)
      !csHigh && !sclkFall && !csFall ##1 !csHigh |-> $stable(spiDout)) // R8
      else $error("output changed without falling edge");
   a_shut_clear: assert property (@(posedge clk) disable iff (rst)
      shutSync |=> regs[OPMODE_ADDR] == OPMODE_RST) // R14
      else $error("registers kept in shutdown");
   a_por_ready: assert property (@(posedge clk) disable iff (rst)
      porPulse |=> idleMode == SRPMC_READY) // R17
      else $error("not ready after power-on");
   a_tune_xtal: assert property (@(posedge clk) disable iff (rst)
      regs[OPMODE_ADDR][SYNTH_BIT] && radioState != SRPMC_SHUT |-> xtalOn) // R24
      else $error("crystal off in tune");
   a_addr_incr: assert property (@(posedge clk) disable iff (rst || csHigh || csFall)
      sclkRise && bitCnt == BIT_LAST && inData |=> addr == $past(addr) + 7'h01) // R10
      else $error("burst address not incremented");
   a_standby_zero: assert property (@(posedge clk) disable iff (rst)
      regs[OPMODE_ADDR] == 8'h00 |-> idleMode == SRPMC_STANDBY) // R19
      else $error("zero not standby");
   a_sleep_wut: assert property (@(posedge clk) disable iff (rst)
      regs[OPMODE_ADDR] == 8'h40 |-> idleMode == SRPMC_SLEEP) // R20
      else $error("40h not sleep");

endmodule // srpmc_top

//--- test/srpmc_host_model.sv
`timescale 1ns/1ps
module srpmc_host_model (
   input  wire logic clk,
   output logic      spiClk,
   output logic      spiDin,
   output logic      chip_select_n,
   input  wire logic spiDout,
   input  wire logic spiDoutOe_n
);
   logic misoLine;

   // Data line as the host sees it, pulled up when released
   assign misoLine = spiDoutOe_n ? 1'b1 : spiDout;

   // Idle bus, clock parked low
   initial begin
      spiClk = 1'b0;
      spiDin = 1'b0;
      chip_select_n = 1'b1;
   end

   // Half serial period of 16 ns, four system clocks per phase
   task automatic half();
      repeat (4) @(posedge clk);
   endtask

   // Flag, address and nb bytes, MSB first; select left low, clock left high
   task automatic frame(input logic wr, input logic [6:0] a, input int nb,
                        input logic [31:0] wd, output logic [31:0] rd);
      logic [39:0] bits;
      bits = {wr, a, wd};
      rd = '0;
      @(posedge clk);
      chip_select_n <= 1'b0;
      for (int k = 0; k < 8 + 8 * nb; k++) begin
         spiDin <= bits[39-k];
         half();
         spiClk <= 1'b1;
         half();
         if (k >= 8) rd[39-k] = misoLine;
         if (k < 7 + 8 * nb) spiClk <= 1'b0;
      end
   endtask

   // Select raised, clock parked, data line scrambled while deselected
   task automatic release_sel();
      chip_select_n <= 1'b1;
      half();
      spiClk <= 1'b0;
      spiDin <= ~spiDin;
      half();
      half();
   endtask
endmodule // srpmc_host_model

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
   import srpmc_pkg::*;
   localparam int unsigned T_SHUT = 400;
   localparam int unsigned T_STBY = 200;
   localparam int unsigned T_RDY  = 60;
   localparam int unsigned T_TUNE = 40;
   logic         clk, rst, shutdownPin, spiClk, spiDin, csN, spiDout, oeN;
   srpmc_state_t radioState;
   srpmc_idle_t  idleMode;
   logic         entryBusy, xtalOn, synthOn, wakeTimerOn, lowBatOn, tempSensOn, porPulse;
   int           miscompares = 0;
   int           comparisons = 0;
   int           n;
   logic [31:0]  seed = 32'hF053;
   logic [31:0]  d;
   logic [6:0]   a;
   logic [7:0]   modeVal [6] = '{8'h00, 8'h40, 8'h10, 8'h20, 8'h02, 8'h01};
   srpmc_idle_t  modeExp [6] = '{SRPMC_STANDBY, SRPMC_SLEEP, SRPMC_SENSOR, SRPMC_SENSOR,
                                 SRPMC_TUNE, SRPMC_READY};

   srpmc_top #(.SHUT_CYC(T_SHUT), .STBY_CYC(T_STBY), .READY_CYC(T_RDY), .TUNE_CYC(T_TUNE)) dut (
      .clk(clk), .rst(rst), .spiClk(spiClk), .spiDin(spiDin), .chip_select_n(csN),
      .shutdown_pin(shutdownPin), .spiDout(spiDout), .spiDoutOe_n(oeN),
      .radioState(radioState), .idleMode(idleMode), .entryBusy(entryBusy), .xtalOn(xtalOn),
      .synthOn(synthOn), .wakeTimerOn(wakeTimerOn), .lowBatOn(lowBatOn),
      .tempSensOn(tempSensOn), .porPulse(porPulse));
   srpmc_host_model host (.clk(clk), .spiClk(spiClk), .spiDin(spiDin), .chip_select_n(csN),
      .spiDout(spiDout), .spiDoutOe_n(oeN));

   // System clock, 4 ns
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Pseudo-random source
   function automatic logic [31:0] rnd();
      seed = seed[0] ? ((seed >> 1) ^ 32'h80200003) : (seed >> 1);
      return seed;
   endfunction

   // Byte-wide comparison
   task automatic chk_byte(input string w, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", w, e, g);
      end
   endtask

   // Single-bit comparison
   task automatic chk_flag(input string w, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %b seen %b", w, e, g);
      end
   endtask

   // Register write frame
   task automatic wr_reg(input logic [6:0] ad, input int nb, input logic [31:0] v);
      logic [31:0] r;
      host.frame(1'b1, ad, nb, v, r);
      host.release_sel();
   endtask

   // Read frame with random data field, checks bytes, hold and release
   task automatic rd_reg(input logic [6:0] ad, input int nb, input logic [31:0] e);
      logic [31:0] r;
      host.frame(1'b0, ad, nb, rnd(), r);
      for (int k = 0; k < nb; k++) chk_byte("read data", e[31-8*k -: 8], r[31-8*k -: 8]);
      chk_flag("held last bit", e[32-8*nb], host.misoLine);
      host.release_sel();
      chk_flag("released line", 1'b1, host.misoLine);
      chk_flag("output enable", 1'b1, oeN);
   endtask

   // Bounded wait for a radio state, cycles counted in n
   task automatic wait_state(input srpmc_state_t s, input int lim);
      n = 0;
      // Entry counts as done once the state shows and its entry wait is over
      while ((radioState !== s || entryBusy !== 1'b0) && n < lim) begin
         @(posedge clk);
         n++;
      end
      chk_byte("radio state", 8'(s), 8'(radioState));
   endtask

   // Shutdown pin released, power-on pulse and default sub-mode
   task automatic power_up();
      shutdownPin <= 1'b0;
      n = 0;
      repeat (12) begin
         @(posedge clk);
         if (porPulse === 1'b1) n++;
      end
      chk_byte("power-on pulses", 8'h01, 8'(n));
      wait_state(SRPMC_IDLE, 100);
      chk_byte("idle sub-mode", 8'(SRPMC_READY), 8'(idleMode));
   endtask

   task automatic wrap_up();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (40000) @(posedge clk);
      miscompares++;
      wrap_up();
   end

   // Main sequence
   initial begin
      rst <= 1'b1;
      shutdownPin <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      chk_byte("radio state", 8'(SRPMC_SHUT), 8'(radioState));
      power_up();
      rd_reg(7'h03, 2, 32'h0);
      for (int i = 0; i < 8; i++) begin
         d = rnd();
         a = (i == 0) ? 7'h7F : d[22:16];
         if (a == OPMODE_ADDR) a = 7'h08;
         wr_reg(a, 1, {d[7:0], 24'h0});
         rd_reg(a, 1, {d[7:0], 24'h0});
         rd_reg(a, 1, {d[7:0], 24'h0});
      end
      d = rnd();
      wr_reg(7'h7E, 4, d);
      rd_reg(7'h7E, 4, d);
      wr_reg(OPMODE_ADDR, 1, {8'h09, 24'h0});
      chk_flag("entry busy", 1'b1, entryBusy);
      wait_state(SRPMC_TX, 600);
      // First request after power-up still pays the shutdown entry time
      chk_flag("entry time", 1'b1, n <= T_SHUT && n + 24 >= T_SHUT);
      wr_reg(OPMODE_ADDR, 1, {8'h05, 24'h0});
      wait_state(SRPMC_RX, 600);
      chk_flag("entry time", 1'b1, n <= T_TUNE && n + 24 >= T_TUNE);
      wr_reg(OPMODE_ADDR, 1, {8'h00, 24'h0});
      wait_state(SRPMC_IDLE, 600);
      wr_reg(OPMODE_ADDR, 1, {8'h08, 24'h0});
      wait_state(SRPMC_TX, 600);
      chk_flag("entry time", 1'b1, n <= T_STBY && n + 24 >= T_STBY);
      for (int i = 0; i < 6; i++) begin
         wr_reg(OPMODE_ADDR, 1, {modeVal[i], 24'h0});
         wait_state(SRPMC_IDLE, 600);
         chk_byte("idle sub-mode", 8'(modeExp[i]), 8'(idleMode));
         chk_flag("crystal", modeVal[i][XTAL_BIT] | modeVal[i][SYNTH_BIT], xtalOn);
         chk_flag("synthesizer", modeVal[i][SYNTH_BIT], synthOn);
         chk_flag("wake timer", modeVal[i][WUT_BIT], wakeTimerOn);
         chk_flag("battery sensor", modeVal[i][LBAT_BIT], lowBatOn);
         chk_flag("temperature sensor", modeVal[i][TSENS_BIT], tempSensOn);
         if (i == 0) wr_reg(7'h11, 1, 32'h3C00_0000);
         if (i == 0) rd_reg(7'h11, 1, 32'h3C00_0000);
      end
      // Transmit request from ready mode
      wr_reg(OPMODE_ADDR, 1, {8'h09, 24'h0});
      wait_state(SRPMC_TX, 600);
      chk_flag("entry time", 1'b1, n <= T_RDY && n + 24 >= T_RDY);
      wr_reg(OSCCTL_ADDR, 1, 32'h0200_0000);
      wr_reg(OSCCTL_ADDR, 1, 32'h0000_0000);
      wr_reg(7'h34, 1, 32'h7700_0000);
      wr_reg(OPMODE_ADDR, 1, 32'h8000_0000);
      rd_reg(7'h34, 1, 32'h0);
      chk_byte("idle sub-mode", 8'(SRPMC_READY), 8'(idleMode));
      wr_reg(7'h33, 1, 32'hA500_0000);
      shutdownPin <= 1'b1;
      repeat (6) @(posedge clk);
      chk_byte("radio state", 8'(SRPMC_SHUT), 8'(radioState));
      wr_reg(7'h33, 1, 32'h5A00_0000);
      power_up();
      rd_reg(7'h33, 1, 32'h0);
      wrap_up();
   end
endmodule // tb
